// ---- core/dmic_pin_widget_consts.vh ----
`ifndef DMIC_PIN_WIDGET_CONSTS_VH
`define DMIC_PIN_WIDGET_CONSTS_VH
// twelve-bit verb ids (4-bit id verbs carry payload in low bits)
`define VERB_GET_PARAM      12'hF00
`define VERB_GET_PWR        12'hF05
`define VERB_SET_PWR        12'h705
`define VERB_GET_PINCTL     12'hF07
`define VERB_SET_PINCTL     12'h707
`define VERB_SET_CFG0       12'h71C
`define VERB_SET_CFG1       12'h71D
`define VERB_SET_CFG2       12'h71E
`define VERB_SET_CFG3       12'h71F
`define VERB_GET_CFG0       12'hF1C
`define VERB_GET_CFG1       12'hF1D
`define VERB_GET_CFG2       12'hF1E
`define VERB_GET_CFG3       12'hF1F
// four-bit verb ids for amplifier access
`define VERB4_GET_AMP       4'hB
`define VERB4_SET_AMP       4'h3
// amplifier payload fields
`define AMP_GET_LEFT_BIT    13
`define AMP_SET_LEFT_BIT    13
`define AMP_SET_RIGHT_BIT   12
`define AMP_SET_INPUT_BIT   14
// parameter ids
`define PARAM_WIDGET_CAPS   8'h09
`define PARAM_PIN_CAPS      8'h0C
// widget capabilities: pin complex, power control, input amp, stereo
`define WIDGET_CAPS_VALUE   32'h0040_0403
// pin capabilities: input capable only
`define PIN_CAPS_VALUE      32'h0000_0020
// power state response fields
`define PWR_LOST_BIT        10
`define PWR_ERR_BIT         8
`define PWR_ACT_LSB         4
`define PWR_ACT_RESET       2'h3
`define PWR_SET_RESET       2'h0
`define PWR_STATE_MAX       2'h3
// pin control field
`define PINCTL_IN_BIT       5
`define PINCTL_RESET        1'b0
// verb field positions
`define VERB_ID_MSB         19
`define VERB_ID_LSB         8
`define VERB4_ID_LSB        16
`define PAY_MSB             7
`define PAY_LSB             0
// gain field position inside the amplifier payload
`define GAIN_LSB            0
// power fields inside payload and response
`define PWR_SET_MSB         1
`define PWR_SET_LSB         0
`define PWR_ACT_MSB         5
`define ERR_RESET           1'b0
`define LOST_RESET          1'b1
// response and configuration default layout
`define RESP_W              32
`define CFG_BYTE_W          8
`define CFG_BYTES           4
// configuration default reset value
`define CFG_DEFAULT_RESET   32'h90A3_0140
`endif

// ---- core/dmic_pin_widget_regs.v ----
// What this block does
// - capability type field reads pin complex
// - capability reports power state control
// - input amp present, no output amp
// - stereo stream, analog not digital
// - sample delay field reads zero
// - connection list, unsolicited, other caps zero
// - pin caps: input only, no output
// - bias level support field reads zero
// - no powerdown, presence or impedance sense
// - two-bit left and right gains
// - settings lost set on reset, cleared
// - power error bit, reset zero
// - actual power state, reset three
// - requested power state, verb 705
// - input enable bit five, verb 707
// - config default written and read bytewise
// - connectivity default fixed function
// - location default 10h
// - default device microphone input
// - connection type internal default
// - misc field default 1h
// - colour, association, sequence defaults
`include "dmic_pin_widget_consts.vh"
`default_nettype none
module dmic_pin_widget_regs
#(
    parameter GAIN_W = 2
)
(
    input  wire              clk_in,
    input  wire              resetn_in,
    input  wire              func_reset_in,
    input  wire              link_reset_in,
    input  wire              verb_valid_in,
    input  wire [19:0]       verb_in,
    output reg               resp_valid_out,
    output reg  [31:0]       resp_data_out,
    output reg  [GAIN_W-1:0] left_gain_out,
    output reg  [GAIN_W-1:0] right_gain_out,
    output reg  [1:0]        power_state_out,
    output reg               input_enable_out
);
    localparam integer      PAD_W     = `RESP_W - GAIN_W;
    localparam [31:0]       CFG_INIT  = `CFG_DEFAULT_RESET;
    localparam [GAIN_W-1:0] GAIN_INIT = {GAIN_W{1'b0}};

    reg                 rst_s1_r;
    reg                 rst_s2_r;
    reg  [GAIN_W-1:0]   left_gain_r;
    reg  [GAIN_W-1:0]   left_gain_nxt;
    reg  [GAIN_W-1:0]   right_gain_r;
    reg  [GAIN_W-1:0]   right_gain_nxt;
    reg  [1:0]          pwr_set_r;
    reg  [1:0]          pwr_set_nxt;
    reg  [1:0]          pwr_act_r;
    reg  [1:0]          pwr_act_nxt;
    reg                 pwr_err_r;
    reg                 pwr_err_nxt;
    reg                 lost_r;
    reg                 lost_nxt;
    reg                 in_en_r;
    reg                 in_en_nxt;
    reg  [31:0]         resp_nxt;
    reg  [GAIN_W-1:0]   amp_read;
    integer             lane_i;
    wire [31:0]         cfg_w;
    wire                soft_rst;
    wire                take;
    wire [11:0]         vid;
    wire [7:0]          pay;
    wire [3:0]          vid4;
    wire                amp_set;
    wire                amp_get;

    assign vid      = verb_in[`VERB_ID_MSB:`VERB_ID_LSB];
    assign pay      = verb_in[`PAY_MSB:`PAY_LSB];
    assign vid4     = verb_in[`VERB_ID_MSB:`VERB4_ID_LSB];
    assign soft_rst = func_reset_in | link_reset_in;
    // a soft reset swallows a verb in the same cycle, so nothing half-applies
    assign take     = verb_valid_in & ~soft_rst;
    assign amp_set  = (vid4 == `VERB4_SET_AMP);
    assign amp_get  = (vid4 == `VERB4_GET_AMP);

    // set verbs clear the lost flag, and so does the get power state verb
    function is_set_verb;
        input [19:0] v;
        reg   [11:0] id;
        begin
            id = v[`VERB_ID_MSB:`VERB_ID_LSB];
            is_set_verb = (v[`VERB_ID_MSB:`VERB4_ID_LSB] == `VERB4_SET_AMP) ||
                          (id == `VERB_SET_PWR) ||
                          (id == `VERB_SET_PINCTL) ||
                          ((id >= `VERB_SET_CFG0) && (id <= `VERB_SET_CFG3));
        end
    endfunction

    // verb id of one configuration byte lane
    function [11:0] cfg_verb;
        input [11:0] base;
        input integer lane;
        begin
            cfg_verb = base + lane[11:0];
        end
    endfunction

    function [GAIN_W-1:0] gain_field;
        input [19:0] v;
        begin
            gain_field = v[`GAIN_LSB+GAIN_W-1:`GAIN_LSB];
        end
    endfunction

    // release through two flops so every register leaves reset on one edge
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // anything not decoded below answers zero
    always @*
    begin
        resp_nxt = 32'h0000_0000;
        amp_read = verb_in[`AMP_GET_LEFT_BIT] ? left_gain_r : right_gain_r;
        if (amp_get)
            resp_nxt = {{PAD_W{1'b0}}, amp_read};
        else
        begin
            case (vid)
                `VERB_GET_PARAM:
                begin
                    if (pay == `PARAM_WIDGET_CAPS)
                        resp_nxt = `WIDGET_CAPS_VALUE;
                    else if (pay == `PARAM_PIN_CAPS)
                        resp_nxt = `PIN_CAPS_VALUE;
                    else
                        resp_nxt = 32'h0000_0000;
                end
                `VERB_GET_PWR:
                begin
                    resp_nxt[`PWR_LOST_BIT] = lost_r;
                    resp_nxt[`PWR_ERR_BIT] = pwr_err_r;
                    resp_nxt[`PWR_ACT_MSB:`PWR_ACT_LSB] = pwr_act_r;
                    resp_nxt[`PWR_SET_MSB:`PWR_SET_LSB] = pwr_set_r;
                end
                `VERB_GET_PINCTL:
                    resp_nxt[`PINCTL_IN_BIT] = in_en_r;
                default:
                    resp_nxt = 32'h0000_0000;
            endcase
            for (lane_i = 0; lane_i < `CFG_BYTES; lane_i = lane_i + 1)
            begin
                if (vid == cfg_verb(`VERB_GET_CFG0, lane_i))
                    resp_nxt = {24'h00_0000, cfg_w[lane_i*`CFG_BYTE_W +: `CFG_BYTE_W]};
            end
        end
    end

    always @*
    begin
        left_gain_nxt  = left_gain_r;
        right_gain_nxt = right_gain_r;
        if (take && amp_set && verb_in[`AMP_SET_INPUT_BIT])
        begin
            if (verb_in[`AMP_SET_LEFT_BIT])
                left_gain_nxt = gain_field(verb_in);
            if (verb_in[`AMP_SET_RIGHT_BIT])
                right_gain_nxt = gain_field(verb_in);
        end
    end

    always @*
    begin
        pwr_set_nxt = pwr_set_r;
        pwr_act_nxt = pwr_act_r;
        pwr_err_nxt = pwr_err_r;
        if (take && vid == `VERB_SET_PWR)
        begin
            // every state can be entered, so actual follows the request at once
            pwr_set_nxt = pay[`PWR_SET_MSB:`PWR_SET_LSB];
            pwr_act_nxt = pay[`PWR_SET_MSB:`PWR_SET_LSB];
            pwr_err_nxt = `ERR_RESET;
        end
    end

    // a soft reset in the same cycle as a clear wins
    always @*
    begin
        lost_nxt = lost_r;
        if (take && (is_set_verb(verb_in) || vid == `VERB_GET_PWR))
            lost_nxt = 1'b0;
    end

    always @*
    begin
        in_en_nxt = in_en_r;
        if (take && vid == `VERB_SET_PINCTL)
            in_en_nxt = pay[`PINCTL_IN_BIT];
    end

    always @(posedge clk_in or negedge rst_s2_r)
    begin
        if (!rst_s2_r)
        begin
            left_gain_r  <= GAIN_INIT;
            right_gain_r <= GAIN_INIT;
        end
        else if (soft_rst)
        begin
            left_gain_r  <= GAIN_INIT;
            right_gain_r <= GAIN_INIT;
        end
        else
        begin
            left_gain_r  <= left_gain_nxt;
            right_gain_r <= right_gain_nxt;
        end
    end

    always @(posedge clk_in or negedge rst_s2_r)
    begin
        if (!rst_s2_r)
        begin
            pwr_set_r <= `PWR_SET_RESET;
            pwr_act_r <= `PWR_ACT_RESET;
            pwr_err_r <= `ERR_RESET;
        end
        else if (soft_rst)
        begin
            pwr_set_r <= `PWR_SET_RESET;
            pwr_act_r <= `PWR_ACT_RESET;
            pwr_err_r <= `ERR_RESET;
        end
        else
        begin
            pwr_set_r <= pwr_set_nxt;
            pwr_act_r <= pwr_act_nxt;
            pwr_err_r <= pwr_err_nxt;
        end
    end

    always @(posedge clk_in or negedge rst_s2_r)
    begin
        if (!rst_s2_r)
        begin
            lost_r <= `LOST_RESET;
        end
        else if (soft_rst)
        begin
            lost_r <= `LOST_RESET;
        end
        else
        begin
            lost_r <= lost_nxt;
        end
    end

    always @(posedge clk_in or negedge rst_s2_r)
    begin
        if (!rst_s2_r)
        begin
            in_en_r <= `PINCTL_RESET;
        end
        else if (soft_rst)
        begin
            in_en_r <= `PINCTL_RESET;
        end
        else
        begin
            in_en_r <= in_en_nxt;
        end
    end

    // configuration default survives function and link resets
    genvar g;
    generate
        for (g = 0; g < `CFG_BYTES; g = g + 1)
        begin : cfg_lane
            reg  [`CFG_BYTE_W-1:0] byte_r;
            assign cfg_w[g*`CFG_BYTE_W +: `CFG_BYTE_W] = byte_r;
            always @(posedge clk_in or negedge rst_s2_r)
            begin
                if (!rst_s2_r)
                    byte_r <= CFG_INIT[g*`CFG_BYTE_W +: `CFG_BYTE_W];
                else if (take && vid == cfg_verb(`VERB_SET_CFG0, g))
                    byte_r <= pay;
            end
        end
    endgenerate

    always @(posedge clk_in or negedge rst_s2_r)
    begin
        if (!rst_s2_r)
        begin
            resp_valid_out <= 1'b0;
        end
        else if (soft_rst)
        begin
            resp_valid_out <= 1'b0;
        end
        else
        begin
            resp_valid_out <= take;
        end
    end

    always @(posedge clk_in or negedge rst_s2_r)
    begin
        if (!rst_s2_r)
        begin
            resp_data_out <= 32'h0000_0000;
        end
        else if (soft_rst)
        begin
            resp_data_out <= 32'h0000_0000;
        end
        else
        begin
            resp_data_out <= take ? resp_nxt : 32'h0000_0000;
        end
    end

    always @(posedge clk_in or negedge rst_s2_r)
    begin
        if (!rst_s2_r)
        begin
            left_gain_out  <= GAIN_INIT;
            right_gain_out <= GAIN_INIT;
        end
        else if (soft_rst)
        begin
            left_gain_out  <= GAIN_INIT;
            right_gain_out <= GAIN_INIT;
        end
        else
        begin
            left_gain_out  <= left_gain_r;
            right_gain_out <= right_gain_r;
        end
    end

    always @(posedge clk_in or negedge rst_s2_r)
    begin
        if (!rst_s2_r)
        begin
            power_state_out <= `PWR_ACT_RESET;
        end
        else if (soft_rst)
        begin
            power_state_out <= `PWR_ACT_RESET;
        end
        else
        begin
            power_state_out <= pwr_act_r;
        end
    end

    always @(posedge clk_in or negedge rst_s2_r)
    begin
        if (!rst_s2_r)
        begin
            input_enable_out <= `PINCTL_RESET;
        end
        else if (soft_rst)
        begin
            input_enable_out <= `PINCTL_RESET;
        end
        else
        begin
            input_enable_out <= in_en_r;
        end
    end
endmodule
`default_nettype wire

// ---- verif/dmic_pin_widget_regs_assertions.sv ----
`default_nettype none
module dmic_pin_widget_regs_assertions
(
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic        func_reset_in,
    input wire logic        link_reset_in,
    input wire logic        verb_valid_in,
    input wire logic [19:0] verb_in,
    input wire logic        resp_valid_out,
    input wire logic [31:0] resp_data_out,
    input wire logic [1:0]  left_gain_out,
    input wire logic [1:0]  power_state_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // soft resets swallow verbs, so answers are only promised outside them
    wire logic soft_w = func_reset_in | link_reset_in;
    a_answer_follows_verb: assert property (verb_valid_in && !soft_w |=> resp_valid_out)
        else $error("verb got no answer");
    a_answer_needs_verb: assert property (resp_valid_out |-> $past(verb_valid_in))
        else $error("answer without verb");
    a_idle_data_zero: assert property (!resp_valid_out |-> resp_data_out == 32'h0)
        else $error("data outside answer");
    a_widget_caps_value: assert property (resp_valid_out && $past(verb_in) == 20'hF0009
        |-> resp_data_out == 32'h0040_0403) else $error("widget caps wrong");
    a_pin_caps_value: assert property (resp_valid_out && $past(verb_in) == 20'hF000C
        |-> resp_data_out == 32'h20) else $error("pin caps wrong");
    a_power_reserved_zero: assert property (resp_valid_out && $past(verb_in) == 20'hF0500
        |-> (resp_data_out & 32'hFFFF_FBCC) == 32'h0) else $error("power reserved set");
    a_soft_reset_outputs: assert property (soft_w |-> ##2
        (power_state_out == 2'h3 && left_gain_out == 2'h0)) else $error("soft reset missed");
    a_power_follows_set: assert property (verb_valid_in && !soft_w && verb_in[19:8] == 12'h705
        |-> ##2 power_state_out == $past(verb_in[1:0], 2)) else $error("power not taken");
endmodule
bind dmic_pin_widget_regs dmic_pin_widget_regs_assertions u_chk
(
    .clk_in(clk_in), .resetn_in(resetn_in), .func_reset_in(func_reset_in),
    .link_reset_in(link_reset_in), .verb_valid_in(verb_valid_in), .verb_in(verb_in),
    .resp_valid_out(resp_valid_out), .resp_data_out(resp_data_out),
    .left_gain_out(left_gain_out), .power_state_out(power_state_out)
);
`default_nettype wire

// ---- verif/hda_host_model.sv ----
`default_nettype none
module hda_host_model
(
    input  wire logic        clk_in,
    input  wire logic        resp_valid_in,
    input  wire logic [31:0] resp_data_in,
    output var  logic        verb_valid_out,
    output var  logic [19:0] verb_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        verb_valid_out = 1'b0;
        verb_out = 20'h0;
    end
    // one verb per call; config bytes go one set verb each
    task automatic issue(input logic [19:0] v, output logic [32:0] got);
        @(posedge clk_in);
        verb_valid_out <= 1'b1;
        verb_out <= v;
        @(posedge clk_in);
        verb_valid_out <= 1'b0;
        verb_out <= ~v;
        #1;
        got = {resp_valid_in, resp_data_in};
    endtask
endmodule
`default_nettype wire

// ---- verif/dmic_pin_widget_regs_tb.sv ----
`default_nettype none
module dmic_pin_widget_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        func_reset_in = 1'b0;
    logic        link_reset_in = 1'b0;
    logic        verb_valid;
    logic [19:0] verb;
    logic        resp_valid;
    logic [31:0] resp_data;
    logic [1:0]  left_gain, right_gain, power_state;
    logic        input_enable;
    logic [32:0] got;
    logic [51:0] steps [0:23];
    int          failures = 0;
    int          samples_checked = 0;
    initial
    begin
        forever #2 clk_in = ~clk_in;
    end
    dmic_pin_widget_regs DUT (.clk_in(clk_in), .resetn_in(resetn_in),
        .func_reset_in(func_reset_in), .link_reset_in(link_reset_in),
        .verb_valid_in(verb_valid), .verb_in(verb), .resp_valid_out(resp_valid),
        .resp_data_out(resp_data), .left_gain_out(left_gain), .right_gain_out(right_gain),
        .power_state_out(power_state), .input_enable_out(input_enable));
    hda_host_model HOST (.clk_in(clk_in), .resp_valid_in(resp_valid),
        .resp_data_in(resp_data), .verb_valid_out(verb_valid), .verb_out(verb));
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #(4 * 1000);
        failures++;
        end_sim();
    end
    initial
    begin
        // verbs 00000h and 00001h stand for a function or link reset pulse
        steps = '{{20'hF0500, 32'h430}, {20'hF0500, 32'h30},
            {20'hF0009, 32'h400403}, {20'hF000C, 32'h20},
            {20'hF1C00, 32'h40}, {20'hF1D00, 32'h1},
            {20'hF1E00, 32'hA3}, {20'hF1F00, 32'h90},
            {20'h36002, 32'h0}, {20'h35003, 32'h0},
            {20'hB2000, 32'h2}, {20'hB0000, 32'h3},
            {20'h707FF, 32'h0}, {20'hF0700, 32'h20},
            {20'h71CA5, 32'h0}, {20'h70502, 32'h0}, {20'hF0500, 32'h22},
            {20'h00000, 32'h0}, {20'hF0500, 32'h430},
            {20'hB2000, 32'h0}, {20'hF1C00, 32'hA5},
            {20'h00001, 32'h0}, {20'h36001, 32'h0}, {20'hF0500, 32'h30}};
        repeat (5) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        foreach (steps[i])
        begin
            if (steps[i][51:33] == 19'h0)
            begin
                @(posedge clk_in);
                func_reset_in <= !steps[i][32];
                link_reset_in <= steps[i][32];
                @(posedge clk_in);
                func_reset_in <= 1'b0;
                link_reset_in <= 1'b0;
            end
            else
            begin
                HOST.issue(steps[i][51:32], got);
                chk(got, {1'b1, steps[i][31:0]});
            end
        end
        chk({26'h0, input_enable, power_state, right_gain, left_gain}, 33'h31);
        end_sim();
    end
endmodule
`default_nettype wire
